// File: hw/roirdt_core.sv
// roirdt_core: region readout chain, delayed transfer and dark reference window control
// assumes the sensor readout engine and network sender answer with done pulses
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module roirdt_core (
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic frame_start_trigger, // capture request pulse
	input wire logic transfer_release_trigger, // release held frame pulse
	input wire logic exposure_done, // sensor exposure finished pulse
	output logic expose_start, // start exposure pulse
	output logic win_valid, // window descriptor valid
	output logic [2:0] win_slot, // region slot of window
	output logic [12:0] win_x, // horizontal start
	output logic [11:0] win_y, // vertical start
	output logic [12:0] win_w, // horizontal width
	output logic [11:0] win_h, // vertical lines
	input wire logic win_done, // window read into memory
	output logic xfer_start, // start network transfer pulse
	input wire logic xfer_done, // network transfer finished
	output logic frame_held, // frame waits for release
	output logic [4:0] dark_margin // dark pixels each side of line
);
	roirdt_pkg::roirdt_regs_type q_r;
	roirdt_pkg::roirdt_regs_type q_nxt;

	// -----------------------------------------------
	// helpers
	// -----------------------------------------------
	function automatic logic [12:0] half13(input logic [12:0] v);
		half13 = {1'b0, v[12:1]};
	endfunction : half13

	function automatic logic [11:0] half12(input logic [11:0] v);
		half12 = {1'b0, v[11:1]};
	endfunction : half12

	// the whole word is compared so that 8 and up never alias onto a legal slot
	function automatic logic slot_ok(input logic [31:0] v);
		slot_ok = (v <= {29'h0000_0000, roirdt_pkg::LAST_SLOT});
	endfunction : slot_ok

	// -----------------------------------------------
	// register decode
	// -----------------------------------------------
	logic wr_ctrl;
	logic wr_slot;
	logic wr_size;
	logic wr_ofs;
	logic wr_next;
	logic multi_ok;
	logic [2:0] succ;

	assign wr_ctrl = reg_wr && (reg_addr == roirdt_pkg::OFS_CTRL);
	assign wr_slot = reg_wr && (reg_addr == roirdt_pkg::OFS_SLOT);
	assign wr_size = reg_wr && (reg_addr == roirdt_pkg::OFS_SIZE);
	assign wr_ofs = reg_wr && (reg_addr == roirdt_pkg::OFS_OFFSET);
	assign wr_next = reg_wr && (reg_addr == roirdt_pkg::OFS_NEXT);
	// successor of the window now shown; always 0-4 because writes are clipped
	assign succ = q_r.next[q_r.cur];

	// -----------------------------------------------
	// exposure mode check
	// -----------------------------------------------
	// permitted exposure modes
	always_comb begin
		case (q_r.exp_mode)
			roirdt_pkg::EXP_TIMED_TRIG: multi_ok = 1'b1;
			roirdt_pkg::EXP_PULSE_WIDTH: multi_ok = 1'b1;
			roirdt_pkg::EXP_PREDUMP: multi_ok = !q_r.bin_v;
			default: multi_ok = 1'b0;
		endcase
	end

	// -----------------------------------------------
	// next state
	// -----------------------------------------------
	always_comb begin
		q_nxt = q_r;
		q_nxt.expose_start = 1'b0;
		q_nxt.xfer_start = 1'b0;
		// read data stand one cycle only, so an idle port shows zero
		q_nxt.rdata = 32'h0000_0000;

		// register writes
		if (wr_ctrl) begin
			q_nxt.mode = reg_wdata[roirdt_pkg::CTRL_MODE_LSB +: 2];
			q_nxt.delay_en = reg_wdata[roirdt_pkg::CTRL_DELAY_BIT];
			q_nxt.bin_h = reg_wdata[roirdt_pkg::CTRL_BINH_BIT];
			q_nxt.bin_v = reg_wdata[roirdt_pkg::CTRL_BINV_BIT];
			q_nxt.exp_mode = reg_wdata[roirdt_pkg::CTRL_EXP_LSB +: 3];
			// edge test on the stored bit: rewriting the same setting never halves twice
			for (int i = 0; i < roirdt_pkg::NUM_SLOTS; i++) begin
				if (!q_r.bin_h && reg_wdata[roirdt_pkg::CTRL_BINH_BIT]) begin
					q_nxt.width[i] = half13(q_r.width[i]);
					q_nxt.ofs_x[i] = half13(q_r.ofs_x[i]);
				end
				if (!q_r.bin_v && reg_wdata[roirdt_pkg::CTRL_BINV_BIT]) begin
					q_nxt.height[i] = half12(q_r.height[i]);
					q_nxt.ofs_y[i] = half12(q_r.ofs_y[i]);
				end
			end
		end
		if (wr_slot && slot_ok(reg_wdata)) begin
			q_nxt.slot = reg_wdata[2:0];
		end
		if (wr_size) begin
			q_nxt.width[q_r.slot] = reg_wdata[roirdt_pkg::FLD_HOR_LSB +: 13];
			q_nxt.height[q_r.slot] = reg_wdata[roirdt_pkg::FLD_VER_LSB +: 12];
		end
		if (wr_ofs) begin
			q_nxt.ofs_x[q_r.slot] = reg_wdata[roirdt_pkg::FLD_HOR_LSB +: 13];
			q_nxt.ofs_y[q_r.slot] = reg_wdata[roirdt_pkg::FLD_VER_LSB +: 12];
		end
		// successor write, out-of-range clipped to last slot
		if (wr_next) begin
			if (slot_ok(reg_wdata)) begin
				q_nxt.next[q_r.slot] = reg_wdata[2:0];
			end else begin
				q_nxt.next[q_r.slot] = roirdt_pkg::LAST_SLOT;
			end
		end

		// register reads
		if (reg_rd) begin
			case (reg_addr)
				roirdt_pkg::OFS_CTRL: begin
					q_nxt.rdata[roirdt_pkg::CTRL_MODE_LSB +: 2] = q_r.mode;
					q_nxt.rdata[roirdt_pkg::CTRL_DELAY_BIT] = q_r.delay_en;
					q_nxt.rdata[roirdt_pkg::CTRL_BINH_BIT] = q_r.bin_h;
					q_nxt.rdata[roirdt_pkg::CTRL_BINV_BIT] = q_r.bin_v;
					q_nxt.rdata[roirdt_pkg::CTRL_EXP_LSB +: 3] = q_r.exp_mode;
				end
				roirdt_pkg::OFS_SLOT: q_nxt.rdata[2:0] = q_r.slot;
				roirdt_pkg::OFS_SIZE: begin
					q_nxt.rdata[roirdt_pkg::FLD_HOR_LSB +: 13] = q_r.width[q_r.slot];
					q_nxt.rdata[roirdt_pkg::FLD_VER_LSB +: 12] = q_r.height[q_r.slot];
				end
				roirdt_pkg::OFS_OFFSET: begin
					q_nxt.rdata[roirdt_pkg::FLD_HOR_LSB +: 13] = q_r.ofs_x[q_r.slot];
					q_nxt.rdata[roirdt_pkg::FLD_VER_LSB +: 12] = q_r.ofs_y[q_r.slot];
				end
				roirdt_pkg::OFS_NEXT: q_nxt.rdata[2:0] = q_r.next[q_r.slot];
				roirdt_pkg::OFS_STATUS: begin
					q_nxt.rdata[4:0] = q_r.state;
					q_nxt.rdata[7:5] = q_r.cur;
					q_nxt.rdata[12:8] = q_r.visited;
					q_nxt.rdata[16] = multi_ok;
				end
				default: q_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// frame sequence
		case (q_r.state)
			roirdt_pkg::ST_IDLE: begin
				if (frame_start_trigger) begin
					q_nxt.state = roirdt_pkg::ST_EXPOSE;
					q_nxt.expose_start = 1'b1;
					// sequence mode runs like normal mode
					q_nxt.multi = (q_r.mode == roirdt_pkg::MODE_MULTI) && multi_ok;
				end
			end
			roirdt_pkg::ST_EXPOSE: begin
				if (exposure_done) begin
					q_nxt.state = roirdt_pkg::ST_READ;
					q_nxt.cur = 3'h0;
					q_nxt.visited = 5'h01;
					q_nxt.win_valid = 1'b1;
					q_nxt.win_slot = 3'h0;
					q_nxt.win_x = q_r.ofs_x[0];
					q_nxt.win_y = q_r.ofs_y[0];
					q_nxt.win_w = q_r.width[0];
					q_nxt.win_h = q_r.height[0];
				end
			end
			roirdt_pkg::ST_READ: begin
				if (win_done) begin
					if (q_r.multi && !q_r.visited[succ]) begin
						// whole window again, shared pixels included
						q_nxt.cur = succ;
						q_nxt.visited[succ] = 1'b1;
						q_nxt.win_slot = succ;
						q_nxt.win_x = q_r.ofs_x[succ];
						q_nxt.win_y = q_r.ofs_y[succ];
						q_nxt.win_w = q_r.width[succ];
						q_nxt.win_h = q_r.height[succ];
					end else begin
						q_nxt.win_valid = 1'b0;
						if (q_r.delay_en) begin
							q_nxt.state = roirdt_pkg::ST_HOLD;
						end else begin
							q_nxt.state = roirdt_pkg::ST_SEND;
							q_nxt.xfer_start = 1'b1;
						end
					end
				end
			end
			roirdt_pkg::ST_HOLD: begin
				if (transfer_release_trigger) begin
					q_nxt.state = roirdt_pkg::ST_SEND;
					q_nxt.xfer_start = 1'b1;
				end
			end
			roirdt_pkg::ST_SEND: begin
				if (xfer_done) begin
					q_nxt.state = roirdt_pkg::ST_IDLE;
				end
			end
			default: begin
				q_nxt.state = roirdt_pkg::ST_IDLE;
				q_nxt.win_valid = 1'b0;
			end
		endcase
	end

	// -----------------------------------------------
	// state register
	// -----------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q_r.state <= roirdt_pkg::ST_IDLE;
			q_r.mode <= roirdt_pkg::MODE_NORMAL;
			q_r.delay_en <= 1'b0;
			q_r.bin_h <= 1'b0;
			q_r.bin_v <= 1'b0;
			q_r.exp_mode <= roirdt_pkg::EXP_FREE_RUN;
			q_r.slot <= 3'h0;
			q_r.width <= {roirdt_pkg::NUM_SLOTS{roirdt_pkg::RST_WIDTH}};
			q_r.height <= {roirdt_pkg::NUM_SLOTS{roirdt_pkg::RST_HEIGHT}};
			q_r.ofs_x <= {roirdt_pkg::NUM_SLOTS{roirdt_pkg::RST_OFS_X}};
			q_r.ofs_y <= {roirdt_pkg::NUM_SLOTS{roirdt_pkg::RST_OFS_Y}};
			q_r.next <= {roirdt_pkg::NUM_SLOTS{roirdt_pkg::RST_NEXT}};
			q_r.multi <= 1'b0;
			q_r.cur <= 3'h0;
			q_r.visited <= 5'h00;
			q_r.win_valid <= 1'b0;
			q_r.win_slot <= 3'h0;
			q_r.win_x <= 13'h0000;
			q_r.win_y <= 12'h000;
			q_r.win_w <= 13'h0000;
			q_r.win_h <= 12'h000;
			q_r.expose_start <= 1'b0;
			q_r.xfer_start <= 1'b0;
			q_r.rdata <= 32'h0000_0000;
		end else begin
			q_r <= q_nxt;
		end
	end

	// -----------------------------------------------
	// outputs
	// -----------------------------------------------
	assign reg_rdata = q_r.rdata;
	assign expose_start = q_r.expose_start;
	assign win_valid = q_r.win_valid;
	assign win_slot = q_r.win_slot;
	assign win_x = q_r.win_x;
	assign win_y = q_r.win_y;
	assign win_w = q_r.win_w;
	assign win_h = q_r.win_h;
	assign xfer_start = q_r.xfer_start;
	// decoded from the state register: no extra flop, no extra latency
	assign frame_held = (q_r.state == roirdt_pkg::ST_HOLD);
	// margin shrinks to eight under horizontal binning
	// dark pixels pass only if the window covers them
	assign dark_margin = q_r.bin_h ? roirdt_pkg::DARK_MARGIN_BIN2 : roirdt_pkg::DARK_MARGIN_FULL;
endmodule : roirdt_core
`default_nettype wire

// File: hw/roirdt_pkg.sv
// roirdt_pkg: constants and types for the region readout and delayed transfer block
// assumes a single clock domain and a plain register port
package roirdt_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SLOT = 8'h04;
	localparam logic [7:0] OFS_SIZE = 8'h08;
	localparam logic [7:0] OFS_OFFSET = 8'h0C;
	localparam logic [7:0] OFS_NEXT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DELAY_BIT = 2;
	localparam int CTRL_BINH_BIT = 3;
	localparam int CTRL_BINV_BIT = 4;
	localparam int CTRL_EXP_LSB = 5;
	// size and offset field positions
	localparam int FLD_HOR_LSB = 0;
	localparam int FLD_VER_LSB = 16;
	// output mode settings
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SEQUENCE = 2'h1;
	localparam logic [1:0] MODE_MULTI = 2'h2;
	// exposure modes
	localparam logic [2:0] EXP_FREE_RUN = 3'h0;
	localparam logic [2:0] EXP_TIMED_FREE = 3'h1;
	localparam logic [2:0] EXP_TIMED_TRIG = 3'h2;
	localparam logic [2:0] EXP_PULSE_WIDTH = 3'h3;
	localparam logic [2:0] EXP_PREDUMP = 3'h4;
	localparam logic [2:0] EXP_DOUBLE_SHOT = 3'h5;
	// region table
	localparam int NUM_SLOTS = 5;
	localparam logic [2:0] LAST_SLOT = 3'h4;
	localparam logic [12:0] RST_WIDTH = 13'hCE0;
	localparam logic [11:0] RST_HEIGHT = 12'h9A8;
	localparam logic [12:0] RST_OFS_X = 13'h010;
	localparam logic [11:0] RST_OFS_Y = 12'h004;
	localparam logic [2:0] RST_NEXT = 3'h0;
	// dark reference margin per side of a line
	localparam logic [4:0] DARK_MARGIN_FULL = 5'h10;
	localparam logic [4:0] DARK_MARGIN_BIN2 = 5'h08;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_EXPOSE = 5'b00010,
		ST_READ = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_SEND = 5'b10000
	} roirdt_state_type;

	typedef struct packed {
		roirdt_state_type state;
		logic [1:0] mode;
		logic delay_en;
		logic bin_h;
		logic bin_v;
		logic [2:0] exp_mode;
		logic [2:0] slot;
		logic [4:0][12:0] width;
		logic [4:0][11:0] height;
		logic [4:0][12:0] ofs_x;
		logic [4:0][11:0] ofs_y;
		logic [4:0][2:0] next;
		logic multi;
		logic [2:0] cur;
		logic [4:0] visited;
		logic win_valid;
		logic [2:0] win_slot;
		logic [12:0] win_x;
		logic [11:0] win_y;
		logic [12:0] win_w;
		logic [11:0] win_h;
		logic expose_start;
		logic xfer_start;
		logic [31:0] rdata;
	} roirdt_regs_type;
endpackage : roirdt_pkg

// File: sim/roirdt_core_props.sv
// roirdt_core_props: port checks of roirdt_core
// assumes one clock domain; bound into every roirdt_core
`timescale 1ns/1ps
`default_nettype none
module roirdt_core_props (
	input wire logic clk_sys, // clock
	input wire logic arst_n, // reset
	input wire logic frame_start_trigger, // capture
	input wire logic transfer_release_trigger, // release
	input wire logic expose_start, // exposure pulse
	input wire logic win_valid, // window shown
	input wire logic [2:0] win_slot, // slot
	input wire logic [12:0] win_x, // x
	input wire logic [11:0] win_y, // y
	input wire logic [12:0] win_w, // width
	input wire logic [11:0] win_h, // height
	input wire logic win_done, // window done
	input wire logic xfer_start, // send pulse
	input wire logic frame_held, // held
	input wire logic [4:0] dark_margin // margin
);
	// ----
	// assertions
	// ----
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_release;
		frame_held && transfer_release_trigger;
	endsequence
	sequence s_busy_win;
		win_valid && !win_done;
	endsequence
	expose_pulse_a: assert property (expose_start |=> !expose_start)
		else $error("expose start longer than one cycle");
	xfer_pulse_a: assert property (xfer_start |=> !xfer_start)
		else $error("transfer start longer than one cycle");
	held_ignore_a: assert property (frame_held && frame_start_trigger |=> !expose_start)
		else $error("trigger taken while frame held");
	release_xfer_a: assert property (s_release |=> xfer_start && !frame_held)
		else $error("release did not start transfer");
	hold_wait_a: assert property (frame_held && !transfer_release_trigger
		|=> frame_held && !xfer_start) else $error("held frame left without release");
	win_stable_a: assert property (s_busy_win |=> win_valid
		&& $stable({win_slot, win_x, win_y, win_w, win_h})) else $error("window moved early");
	slot_range_a: assert property (win_valid |-> win_slot <= 3'h4)
		else $error("window slot out of range");
	first_slot_a: assert property ($rose(win_valid) |-> win_slot == 3'h0)
		else $error("chain did not start at slot zero");
	dark_margin_a: assert property (dark_margin == 5'h10 || dark_margin == 5'h08)
		else $error("dark margin not sixteen or eight");
endmodule : roirdt_core_props
bind roirdt_core roirdt_core_props props (.clk_sys(clk_sys), .arst_n(arst_n),
	.frame_start_trigger(frame_start_trigger), .transfer_release_trigger(transfer_release_trigger),
	.expose_start(expose_start), .win_valid(win_valid), .win_slot(win_slot), .win_x(win_x),
	.win_y(win_y), .win_w(win_w), .win_h(win_h), .win_done(win_done), .xfer_start(xfer_start),
	.frame_held(frame_held), .dark_margin(dark_margin));
`default_nettype wire

// File: sim/roirdt_core_test.sv
// roirdt_core_test: register and frame sequences for roirdt_core
// assumes roirdt_far answers the exposure, window and send handshakes
`timescale 1ns/1ps
`default_nettype none
module roirdt_core_test;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic trig = 1'b0;
	logic rel = 1'b0;
	logic [3:0] lat = 4'h1;
	wire logic [31:0] rdata;
	wire logic ed, es, wv, wd, xs, xd, fh;
	wire logic [2:0] ws;
	wire logic [12:0] wx, ww;
	wire logic [11:0] wy, wh;
	wire logic [4:0] dm;
	int n_errors = 0;
	int n_tests = 0;
	logic [52:0] got[$];
	logic [12:0] tw[5];
	logic [12:0] tx[5];
	logic [11:0] th[5];
	logic [11:0] ty[5];
	logic [2:0] tn[5] = '{3'h2, 3'h2, 3'h4, 3'h3, 3'h1};
	always #2.5 clk_sys = ~clk_sys;
	roirdt_core DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.frame_start_trigger(trig), .transfer_release_trigger(rel), .exposure_done(ed),
		.expose_start(es), .win_valid(wv), .win_slot(ws), .win_x(wx), .win_y(wy), .win_w(ww),
		.win_h(wh), .win_done(wd), .xfer_start(xs), .xfer_done(xd), .frame_held(fh),
		.dark_margin(dm));
	roirdt_far far (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat), .expose_start(es),
		.win_valid(wv), .xfer_start(xs), .exposure_done(ed), .win_done(wd), .xfer_done(xd));
	always @(posedge clk_sys) if (wv && wd) got.push_back({ws, wx, wy, ww, wh});
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk_sys);
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rdc
	task automatic pulse(input bit t);
		if (t) rel <= 1'b1;
		else trig <= 1'b1;
		@(posedge clk_sys);
		{trig, rel} <= 2'b00;
		@(posedge clk_sys);
	endtask : pulse
	task automatic frame(input logic [31:0] c, input int n);
		int k;
		logic [31:0] v;
		logic [2:0] s;
		wr(roirdt_pkg::OFS_CTRL, c);
		got.delete();
		pulse(1'b0);
		for (k = 0; k < 200 && !(xs || fh); k++) @(posedge clk_sys) #1;
		chk(xs || fh, 1'b1);
		chk(fh, c[2]);
		@(posedge clk_sys);
		v = 32'h0;
		if (c[2]) begin
			pulse(1'b0);
			rd(roirdt_pkg::OFS_STATUS, v);
			chk(v[4:0], 5'h08);
			pulse(1'b1);
		end
		for (k = 0; k < 60 && !v[0]; k++) rd(roirdt_pkg::OFS_STATUS, v);
		chk(v[4:0], 5'h01);
		chk(got.size(), n);
		s = 3'h0;
		for (k = 0; k < n; k++) begin
			chk(got[k], {s, tx[s], ty[s], tw[s], th[s]});
			s = tn[s];
		end
	endtask : frame
	task automatic close_out;
		if (n_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		n_errors++;
		close_out;
	end
	initial begin
		int i;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rdc(roirdt_pkg::OFS_SIZE, 32'h09A80CE0);
		rdc(roirdt_pkg::OFS_OFFSET, 32'h00040010);
		rdc(roirdt_pkg::OFS_NEXT, 32'h0);
		rdc(8'h18, 32'h0);
		chk(dm, 5'h10);
		// overlapping windows, chain 0-2-4-1 then back to 2
		for (i = 0; i < 5; i++) begin
			tw[i] = 13'h100 + 13'(i);
			tx[i] = 13'(i * 8);
			th[i] = 12'h80 + 12'(i);
			ty[i] = 12'(i * 4);
			wr(roirdt_pkg::OFS_SLOT, 32'(i));
			wr(roirdt_pkg::OFS_SIZE, {4'h0, th[i], 3'h0, tw[i]});
			wr(roirdt_pkg::OFS_OFFSET, {4'h0, ty[i], 3'h0, tx[i]});
			wr(roirdt_pkg::OFS_NEXT, {29'h0, tn[i]});
		end
		wr(roirdt_pkg::OFS_SLOT, 32'h3);
		wr(roirdt_pkg::OFS_NEXT, 32'h7);
		rdc(roirdt_pkg::OFS_NEXT, 32'h4);
		wr(roirdt_pkg::OFS_SLOT, 32'h7);
		rdc(roirdt_pkg::OFS_SLOT, 32'h3);
		wr(roirdt_pkg::OFS_SLOT, 32'h8);
		rdc(roirdt_pkg::OFS_SLOT, 32'h3);
		lat <= 4'h0;
		for (i = 0; i < 6; i++) frame({24'h0, 3'(i), 2'h0, i == 4, 2'h2}, (i > 1 && i < 5) ? 4 : 1);
		lat <= 4'h6;
		frame(32'h00000044, 1);
		frame(32'h00000041, 1);
		wr(roirdt_pkg::OFS_SLOT, 32'h1);
		wr(roirdt_pkg::OFS_CTRL, 32'h00000008);
		rdc(roirdt_pkg::OFS_SIZE, {4'h0, th[1], 3'h0, tw[1] >> 1});
		rdc(roirdt_pkg::OFS_OFFSET, {4'h0, ty[1], 3'h0, tx[1] >> 1});
		chk(dm, 5'h08);
		wr(roirdt_pkg::OFS_CTRL, 32'h00000018);
		rdc(roirdt_pkg::OFS_SIZE, {4'h0, th[1] >> 1, 3'h0, tw[1] >> 1});
		wr(roirdt_pkg::OFS_CTRL, 32'h0);
		rdc(roirdt_pkg::OFS_SIZE, {4'h0, th[1] >> 1, 3'h0, tw[1] >> 1});
		chk(dm, 5'h10);
		wr(roirdt_pkg::OFS_SIZE, 32'h09AC0CE0);
		wr(roirdt_pkg::OFS_OFFSET, 32'h00000010);
		rdc(roirdt_pkg::OFS_SIZE, 32'h09AC0CE0);
		rdc(roirdt_pkg::OFS_OFFSET, 32'h00000010);
		wr(roirdt_pkg::OFS_SIZE, 32'h09A80D00);
		wr(roirdt_pkg::OFS_OFFSET, 32'h00040000);
		rdc(roirdt_pkg::OFS_SIZE, 32'h09A80D00);
		rdc(roirdt_pkg::OFS_OFFSET, 32'h00040000);
		wr(roirdt_pkg::OFS_SIZE, 32'h09A80CE0);
		wr(roirdt_pkg::OFS_OFFSET, 32'h00040010);
		wr(roirdt_pkg::OFS_CTRL, 32'h00000008);
		rdc(roirdt_pkg::OFS_OFFSET, 32'h00040008);
		rdc(roirdt_pkg::OFS_SIZE, 32'h09A80670);
		chk(dm, 5'h08);
		close_out;
	end
endmodule : roirdt_core_test
`default_nettype wire

// File: sim/roirdt_far.sv
// roirdt_far: sensor and network sender stand-in for roirdt_core
// assumes the core never asks for two of its handshakes at once
`timescale 1ns/1ps
`default_nettype none
module roirdt_far (
	input wire logic clk_sys, // clock
	input wire logic arst_n, // reset
	input wire logic [3:0] lat, // answer delay
	input wire logic expose_start, // exposure request
	input wire logic win_valid, // window shown
	input wire logic xfer_start, // send request
	output logic exposure_done, // exposure over
	output logic win_done, // window read
	output logic xfer_done // send over
);
	logic [3:0] cnt;
	logic ep;
	logic xp;
	// one delay counter serves all three answers
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			{cnt, ep, xp, exposure_done, win_done, xfer_done} <= '0;
		end else begin
			{exposure_done, win_done, xfer_done} <= 3'b000;
			if (expose_start) ep <= 1'b1;
			if (xfer_start) xp <= 1'b1;
			if (ep || xp || (win_valid && !win_done)) begin
				cnt <= cnt + 4'h1;
				if (cnt == lat) begin
					cnt <= 4'h0;
					{ep, xp} <= 2'b00;
					exposure_done <= ep;
					xfer_done <= xp;
					win_done <= !ep && !xp;
				end
			end
		end
	end
endmodule : roirdt_far
`default_nettype wire
